// *** e1ts_defines.svh ***
// Constants for the E1 time slot 16, signaling and loopback control block.
// Assumes inclusion by bare name; definitions only.
`ifndef E1TS_DEFINES_SVH
`define E1TS_DEFINES_SVH
`define E1TS_ADDR_W 8
`define E1TS_OFF_ALIGN 8'h13
`define E1TS_OFF_SIGC 8'h14
`define E1TS_OFF_CODL 8'h15
`define E1TS_RST_ALIGN 8'h0B
`define E1TS_RST_SIGC 8'h00
`define E1TS_RST_CODL 8'h00
`define E1TS_MSK_ALIGN 8'hFF
`define E1TS_MSK_SIGC 8'hF8
`define E1TS_MSK_CODL 8'hE8
`define E1TS_B_ALARM 2
`define E1TS_B_DOE 7
`define E1TS_B_SOE 6
`define E1TS_B_CCS 5
`define E1TS_B_DEB 4
`define E1TS_B_MSN 3
`define E1TS_B_RXZ 7
`define E1TS_B_MLB 6
`define E1TS_B_TXZ 5
`define E1TS_B_DLB 3
`define E1TS_CLK_KHZ 20000
`define E1TS_DEB_MS 14
`define E1TS_BUF_DEPTH 2'd2
`define E1TS_CODE_ZERO 2'd0
`define E1TS_CODE_MARK 2'd1
`define E1TS_CODE_VIOL 2'd2
`define E1TS_CODE_BAL 2'd3
`define E1TS_DEB_W 19
`define E1TS_ZRUN_MAX 3'd3
`endif

// *** e1ts_pkg.sv ***
// Types shared by the E1 time slot 16 control block.
// Assumes the defines header is compiled alongside.
package e1ts_pkg;
  typedef struct packed {
    logic pos;
    logic neg;
  } e1ts_line_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } e1ts_bus_t;
endpackage

// *** e1ts_ctrl.sv ***
// E1 time slot 16 byte, signaling control, line coding and loopbacks.
// Assumes a synchronous host port, one-cycle line bit ticks and frame strobes.
//
// Contract
// - Frame-zero TS16 bits 1-4 carry alignment register bits 7-4.
// - Bit 5 of frame-zero TS16 carries register bit 3.
// - Bit 6 of frame-zero TS16 carries the remote multiframe alarm.
// - Programmed alarm bit ignored while automatic alarm control is zero.
// - Bits 7 and 8 of frame-zero TS16 carry register bits 1 and 0.
// - Received TS16 loops out only in common channel mode.
// - Backplane data output driven only while its enable bit is set.
// - Backplane signaling output driven only while its enable bit is set.
// - Control bit 5 selects common channel or channel associated signaling.
// - Control bit 4 debounces received signaling for 14 ms.
// - Control bit 3 places signaling nibbles in the upper half.
// - Coding bit 7 enables zero-substitution decoding on receive.
// - Coding bit 5 enables zero-substitution encoding on transmit.
// - Metallic loop feeds transmit line into receiver instead of line inputs.
// - Digital loop feeds transmit stream into receive path.
// - Second link controller connects to TS16 only in common channel mode.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "e1ts_defines.svh"
module e1ts_ctrl
  import e1ts_pkg::*;
#(
  parameter int DEB_CYC = `E1TS_DEB_MS * `E1TS_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire e1ts_bus_t bus,
  output logic [7:0] rd_data,
  input wire logic auto_mf_alarm_ctrl,
  input wire logic rx_mf_loss,
  input wire logic second_link_ctrl,
  input wire logic tx_mf_start,
  input wire logic tx_ts16_strobe,
  input wire logic tx_frame_zero,
  input wire logic [7:0] tx_sig_byte,
  input wire logic [7:0] hdlc_ts16_byte,
  input wire logic [7:0] rx_ts16_byte,
  output logic [7:0] tx_ts16_byte,
  output logic hdlc_ts16_connect,
  output logic tx_ccs_mode,
  input wire logic bp_data_in,
  input wire logic bp_data_in_valid,
  output logic bp_data_in_ready,
  input wire logic tx_tick,
  output e1ts_line_t tx_line,
  input wire e1ts_line_t rx_line,
  input wire logic rx_tick,
  output logic bp_data_out,
  output logic bp_data_out_valid,
  output logic bp_data_out_oe,
  input wire logic [3:0] sig_nibble_tx,
  output logic [7:0] bp_sig_out,
  output logic bp_sig_out_oe,
  input wire logic [7:0] bp_sig_in,
  output logic [3:0] sig_nibble_rx,
  input wire logic [3:0] rx_sig_raw,
  output logic [3:0] rx_sig_state
);
  logic [7:0] align_r;
  logic [7:0] sigc_r;
  logic [7:0] codl_r;
  logic [7:0] rd_data_r;
  logic [7:0] snap_r;
  logic [7:0] ts16_r;
  logic hdlc_conn_r;
  logic ccs_r;
  logic buf_r [2];
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic rdp_r;
  logic wrp_r;
  logic ready_r;
  logic [1:0] pipe_r [4];
  logic par_r;
  logic tpol_r;
  e1ts_line_t txl_r;
  logic [2:0] rxd_r;
  logic rpol_r;
  logic rbit_r;
  logic rvalid_r;
  logic doe_r;
  logic soe_r;
  logic [7:0] sig_out_r;
  logic [3:0] sig_in_r;
  logic [3:0] deb_state_r;
  logic [3:0] deb_cand_r;
  logic [`E1TS_DEB_W-1:0] deb_cnt_r;
  logic push;
  logic pop;
  logic enc_bit;
  logic loop_sel;
  e1ts_line_t rsrc;
  logic rtick;
  logic rpulse;
  logic rpol;
  logic rviol;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic pulse_of(input e1ts_line_t l);
    pulse_of = l.pos ^ l.neg;
  endfunction

  // Host writes; reserved bits are masked so they never steer logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      align_r <= `E1TS_RST_ALIGN;
      sigc_r <= `E1TS_RST_SIGC;
      codl_r <= `E1TS_RST_CODL;
    end else if (bus.wr) begin
      if (hit(bus.addr, `E1TS_OFF_ALIGN)) begin
        align_r <= bus.wdata & `E1TS_MSK_ALIGN;
      end
      if (hit(bus.addr, `E1TS_OFF_SIGC)) begin
        sigc_r <= bus.wdata & `E1TS_MSK_SIGC;
      end
      if (hit(bus.addr, `E1TS_OFF_CODL)) begin
        codl_r <= bus.wdata & `E1TS_MSK_CODL;
      end
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= 8'h00;
    end else if (bus.rd) begin
      if (hit(bus.addr, `E1TS_OFF_ALIGN)) begin
        rd_data_r <= align_r;
      end else if (hit(bus.addr, `E1TS_OFF_SIGC)) begin
        rd_data_r <= sigc_r;
      end else if (hit(bus.addr, `E1TS_OFF_CODL)) begin
        rd_data_r <= codl_r;
      end else begin
        rd_data_r <= 8'h00;
      end
    end else begin
      rd_data_r <= 8'h00;
    end
  end
  assign rd_data = rd_data_r;

  // One snapshot per multiframe keeps the sent byte coherent with host writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap_r <= `E1TS_RST_ALIGN;
    end else if (tx_mf_start) begin
      snap_r <= align_r;
      if (!auto_mf_alarm_ctrl) begin
        snap_r[`E1TS_B_ALARM] <= rx_mf_loss;
      end
    end
  end

  // TS16 source: alignment byte, CAS signaling, link controller or looped data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ts16_r <= 8'h00;
      hdlc_conn_r <= 1'b0;
      ccs_r <= 1'b0;
    end else begin
      ccs_r <= sigc_r[`E1TS_B_CCS];
      hdlc_conn_r <= second_link_ctrl & sigc_r[`E1TS_B_CCS];
      if (tx_ts16_strobe) begin
        if (!sigc_r[`E1TS_B_CCS]) begin
          ts16_r <= tx_frame_zero ? snap_r : tx_sig_byte;
        end else if (second_link_ctrl) begin
          ts16_r <= hdlc_ts16_byte;
        end else begin
          ts16_r <= rx_ts16_byte;
        end
      end
    end
  end
  assign tx_ts16_byte = ts16_r;
  assign hdlc_ts16_connect = hdlc_conn_r;
  assign tx_ccs_mode = ccs_r;

  // Two-entry buffer between backplane input and the line encoder
  assign push = bp_data_in_valid & ready_r;
  assign pop = tx_tick & (cnt_r != 2'd0);
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'd1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'd1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 2'd0;
      rdp_r <= 1'b0;
      wrp_r <= 1'b0;
      ready_r <= 1'b0;
      buf_r[0] <= 1'b0;
      buf_r[1] <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != `E1TS_BUF_DEPTH);
      if (push) begin
        buf_r[wrp_r] <= bp_data_in;
        wrp_r <= ~wrp_r;
      end
      if (pop) begin
        rdp_r <= ~rdp_r;
      end
    end
  end
  assign bp_data_in_ready = ready_r;
  // Underrun sends a space rather than stalling the line clock
  assign enc_bit = pop ? buf_r[rdp_r] : 1'b0;

  // Encoder: four-stage pipe lets a run of four zeros be replaced in place
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        pipe_r[i] <= `E1TS_CODE_ZERO;
      end
      par_r <= 1'b0;
    end else if (tx_tick) begin
      pipe_r[1] <= pipe_r[0];
      pipe_r[2] <= pipe_r[1];
      pipe_r[3] <= pipe_r[2];
      pipe_r[0] <= enc_bit ? `E1TS_CODE_MARK : `E1TS_CODE_ZERO;
      if (enc_bit) begin
        par_r <= ~par_r;
      end
      if (codl_r[`E1TS_B_TXZ] && !enc_bit && pipe_r[0] == `E1TS_CODE_ZERO &&
          pipe_r[1] == `E1TS_CODE_ZERO && pipe_r[2] == `E1TS_CODE_ZERO) begin
        pipe_r[0] <= `E1TS_CODE_VIOL;
        pipe_r[3] <= par_r ? `E1TS_CODE_ZERO : `E1TS_CODE_BAL;
        par_r <= 1'b0;
      end
    end
  end

  // Marks alternate; a violation repeats the previous polarity
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tpol_r <= 1'b0;
      txl_r <= '0;
    end else if (tx_tick) begin
      case (pipe_r[3])
        `E1TS_CODE_MARK, `E1TS_CODE_BAL: begin
          tpol_r <= ~tpol_r;
          txl_r.pos <= ~tpol_r;
          txl_r.neg <= tpol_r;
        end
        `E1TS_CODE_VIOL: begin
          txl_r.pos <= tpol_r;
          txl_r.neg <= ~tpol_r;
        end
        default: begin
          txl_r <= '0;
        end
      endcase
    end
  end
  assign tx_line = txl_r;

  // Both loops take the receiver from the transmit line output
  assign loop_sel = codl_r[`E1TS_B_MLB] | codl_r[`E1TS_B_DLB];
  assign rsrc = loop_sel ? txl_r : rx_line;
  assign rtick = loop_sel ? tx_tick : rx_tick;
  assign rpulse = pulse_of(rsrc);
  assign rpol = rsrc.pos;
  assign rviol = codl_r[`E1TS_B_RXZ] & rpulse & (rpol == rpol_r);

  // Decoder: a violation clears the three held bits, which hid the run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxd_r <= 3'b000;
      rpol_r <= 1'b1;
      rbit_r <= 1'b0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rtick;
      if (rtick) begin
        if (rpulse) begin
          rpol_r <= rpol;
        end
        if (rviol) begin
          rxd_r <= 3'b000;
          rbit_r <= 1'b0;
        end else begin
          rxd_r <= {rxd_r[1:0], rpulse};
          rbit_r <= rxd_r[2];
        end
      end
    end
  end
  assign bp_data_out = rbit_r;
  assign bp_data_out_valid = rvalid_r;

  // Output enables and signaling nibble placement
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doe_r <= 1'b0;
      soe_r <= 1'b0;
      sig_out_r <= 8'h00;
      sig_in_r <= 4'h0;
    end else begin
      doe_r <= sigc_r[`E1TS_B_DOE];
      soe_r <= sigc_r[`E1TS_B_SOE];
      if (sigc_r[`E1TS_B_MSN]) begin
        sig_out_r <= {sig_nibble_tx, 4'h0};
        sig_in_r <= bp_sig_in[7:4];
      end else begin
        sig_out_r <= {4'h0, sig_nibble_tx};
        sig_in_r <= bp_sig_in[3:0];
      end
    end
  end
  assign bp_data_out_oe = doe_r;
  assign bp_sig_out_oe = soe_r;
  assign bp_sig_out = sig_out_r;
  assign sig_nibble_rx = sig_in_r;

  // Debounce accepts a change only after it holds for the full period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deb_state_r <= 4'h0;
      deb_cand_r <= 4'h0;
      deb_cnt_r <= '0;
    end else if (!sigc_r[`E1TS_B_DEB]) begin
      deb_state_r <= rx_sig_raw;
      deb_cand_r <= rx_sig_raw;
      deb_cnt_r <= '0;
    end else if (rx_sig_raw != deb_cand_r) begin
      deb_cand_r <= rx_sig_raw;
      deb_cnt_r <= '0;
    end else if (deb_cnt_r >= `E1TS_DEB_W'(DEB_CYC - 1)) begin
      deb_state_r <= deb_cand_r;
    end else begin
      deb_cnt_r <= deb_cnt_r + `E1TS_DEB_W'(1);
    end
  end
  assign rx_sig_state = deb_state_r;

  // Helper: run of zero line symbols seen on transmit; counting starts only after
  // a nonzero symbol with substitution on, since zeros queued earlier are exempt
  logic [2:0] zrun_r;
  logic zarm_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zarm_r <= 1'b0;
    end else if (!codl_r[`E1TS_B_TXZ]) begin
      zarm_r <= 1'b0;
    end else if (tx_tick && pipe_r[3] != `E1TS_CODE_ZERO) begin
      zarm_r <= 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zrun_r <= 3'd0;
    end else if (!zarm_r) begin
      zrun_r <= 3'd0;
    end else if (tx_tick) begin
      if (pipe_r[3] == `E1TS_CODE_ZERO && zrun_r != 3'd7) begin
        zrun_r <= zrun_r + 3'd1;
      end else if (pipe_r[3] != `E1TS_CODE_ZERO) begin
        zrun_r <= 3'd0;
      end
    end
  end

  a_mfa_bits: assert property (@(posedge clk) disable iff (rst)
    tx_ts16_strobe && tx_frame_zero && !sigc_r[`E1TS_B_CCS] |=>
      tx_ts16_byte[7:4] == $past(snap_r[7:4]))
    else $error("alignment bits not sent");
  a_spare_one: assert property (@(posedge clk) disable iff (rst)
    tx_mf_start ##1 (tx_ts16_strobe && tx_frame_zero && !sigc_r[`E1TS_B_CCS] && !tx_mf_start
      && !bus.wr) |=> tx_ts16_byte[3] == $past(align_r[3], 2))
    else $error("spare bit one wrong");
  a_alarm_bit: assert property (@(posedge clk) disable iff (rst)
    tx_mf_start && !auto_mf_alarm_ctrl |=> snap_r[`E1TS_B_ALARM] == $past(rx_mf_loss))
    else $error("alarm bit source wrong");
  a_spare_pair: assert property (@(posedge clk) disable iff (rst)
    tx_mf_start |=> snap_r[1:0] == $past(align_r[1:0]))
    else $error("spare bits two three wrong");
  a_snap_hold: assert property (@(posedge clk) disable iff (rst)
    !tx_mf_start |=> $stable(snap_r))
    else $error("snapshot changed mid multiframe");
  a_data_oe: assert property (@(posedge clk) disable iff (rst)
    bus.wr && hit(bus.addr, `E1TS_OFF_SIGC) |=> ##1 bp_data_out_oe == $past(bus.wdata[7], 2))
    else $error("data output enable wrong");
  a_sig_oe: assert property (@(posedge clk) disable iff (rst)
    bus.wr && hit(bus.addr, `E1TS_OFF_SIGC) |=> ##1 bp_sig_out_oe == $past(bus.wdata[6], 2))
    else $error("signaling output enable wrong");
  a_ccs_loop: assert property (@(posedge clk) disable iff (rst)
    tx_ts16_strobe && sigc_r[`E1TS_B_CCS] && !second_link_ctrl |=>
      tx_ts16_byte == $past(rx_ts16_byte))
    else $error("received TS16 not looped");
  a_link_conn: assert property (@(posedge clk) disable iff (rst)
    hdlc_ts16_connect |-> $past(sigc_r[`E1TS_B_CCS]))
    else $error("link controller on TS16 outside CCS");
  a_nibble_pos: assert property (@(posedge clk) disable iff (rst)
    sigc_r[`E1TS_B_MSN] |=> bp_sig_out[3:0] == 4'h0 && bp_sig_out[7:4] == $past(sig_nibble_tx))
    else $error("nibble placement wrong");
  a_deb_bypass: assert property (@(posedge clk) disable iff (rst)
    !sigc_r[`E1TS_B_DEB] |=> rx_sig_state == $past(rx_sig_raw))
    else $error("signaling not passed without debounce");
  a_deb_hold: assert property (@(posedge clk) disable iff (rst)
    sigc_r[`E1TS_B_DEB] && $changed(rx_sig_raw) |=> ##1 $stable(rx_sig_state))
    else $error("debounced state changed early");
  a_zero_run: assert property (@(posedge clk) disable iff (rst)
    codl_r[`E1TS_B_TXZ] && zarm_r |-> zrun_r <= `E1TS_ZRUN_MAX)
    else $error("four zeros sent with substitution on");
  a_loop_src: assert property (@(posedge clk) disable iff (rst)
    loop_sel |-> rsrc == tx_line && rtick == tx_tick)
    else $error("loop source not transmit line");
  a_rsvd_read: assert property (@(posedge clk) disable iff (rst)
    bus.rd && hit(bus.addr, `E1TS_OFF_SIGC) |=> rd_data[2:0] == 3'b000)
    else $error("reserved bits read nonzero");
endmodule // e1ts_ctrl

// *** e1ts_far_end.sv ***
// Far-end model: line terminal timing and received E1 line symbols.
// Assumes one clock; ticks are one-cycle pulses every DIV cycles while run is high.
`timescale 1ns/1ps
module e1ts_far_end
  import e1ts_pkg::*;
#(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic mark_en,
  output logic tx_tick,
  output logic rx_tick,
  output e1ts_line_t rx_line
);
  int cnt;
  logic pol_r;
  e1ts_line_t last_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      pol_r <= 1'b1;
      last_r <= 2'h0;
      tx_tick <= 1'b0;
      rx_tick <= 1'b0;
      rx_line <= 2'h3;
    end else begin
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
      tx_tick <= run && cnt == 0;
      rx_tick <= run && cnt == 2;
      if (run && cnt == 2) begin
        // Marks alternate polarity, as plain AMI from the far end
        rx_line <= mark_en ? {pol_r, ~pol_r} : 2'h0;
        last_r <= mark_en ? {pol_r, ~pol_r} : 2'h0;
        pol_r <= pol_r ^ mark_en;
      end else begin
        // Not sampled now: show the inverse so no stale symbol passes for a fresh one
        rx_line <= ~last_r;
      end
    end
  end
endmodule // e1ts_far_end

// *** e1ts_tb.sv ***
// Self-checking bench for the E1 time slot 16 control block.
// Assumes the far-end model supplies line ticks; the bench is host and backplane.
`timescale 1ns/1ps
module testbench;
  import e1ts_pkg::*;
  localparam int DEB = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  e1ts_bus_t bus = '0;
  logic auto = 1'b1, loss = 1'b0, lsel = 1'b0, mfs = 1'b0, stb = 1'b0, f0 = 1'b0;
  logic din = 1'b0, dvld = 1'b0, run = 1'b1, mark = 1'b0;
  logic [7:0] sigb = 8'h3c, hdlb = 8'h5a, rxb = 8'hc3, sin = 8'h00;
  logic [3:0] ntx = 4'h0, raw = 4'h0;
  logic [7:0] rdd, ts, sout;
  logic conn, ccs, rdy, ttk, rtk, dout, dov, doe, soe;
  logic [3:0] nrx, sst;
  e1ts_line_t txl, rxl;
  int bad_count = 0, n_checks = 0, ones = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (dov === 1'b1 && dout === 1'b1) ones <= ones + 1;
  e1ts_ctrl #(.DEB_CYC(DEB)) u_e1ts_ctrl (.clk(clk), .rst(rst), .bus(bus), .rd_data(rdd),
    .auto_mf_alarm_ctrl(auto), .rx_mf_loss(loss), .second_link_ctrl(lsel),
    .tx_mf_start(mfs), .tx_ts16_strobe(stb), .tx_frame_zero(f0), .tx_sig_byte(sigb),
    .hdlc_ts16_byte(hdlb), .rx_ts16_byte(rxb), .tx_ts16_byte(ts), .hdlc_ts16_connect(conn),
    .tx_ccs_mode(ccs), .bp_data_in(din), .bp_data_in_valid(dvld), .bp_data_in_ready(rdy),
    .tx_tick(ttk), .tx_line(txl), .rx_line(rxl), .rx_tick(rtk), .bp_data_out(dout),
    .bp_data_out_valid(dov), .bp_data_out_oe(doe), .sig_nibble_tx(ntx), .bp_sig_out(sout),
    .bp_sig_out_oe(soe), .bp_sig_in(sin), .sig_nibble_rx(nrx), .rx_sig_raw(raw),
    .rx_sig_state(sst));
  e1ts_far_end u_e1ts_far_end (.clk(clk), .rst(rst), .run(run), .mark_en(mark),
    .tx_tick(ttk), .rx_tick(rtk), .rx_line(rxl));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdd;
  endtask
  task automatic ts16(input logic m, input logic z);
    @(posedge clk);
    mfs <= m;
    @(posedge clk);
    mfs <= 1'b0;
    stb <= 1'b1;
    f0 <= z;
    @(posedge clk);
    stb <= 1'b0;
    #1;
  endtask
  // Holds the word until an edge sees ready high
  task automatic wait_acc();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 400);
    if (rdy !== 1'b1) begin
      bad_count++;
    end
    dvld <= 1'b0;
  endtask
  task automatic push(input logic b);
    @(posedge clk);
    din <= b;
    dvld <= 1'b1;
    wait_acc();
  endtask
  // Lets the loop pipeline drain, then counts received ones over 50 ticks
  task automatic window();
    cyc(40);
    ones = 0;
    cyc(200);
  endtask
  task automatic t_regs();
    logic [7:0] d;
    rd(8'h13, d);
    chk(d, 8'h0b);
    rd(8'h15, d);
    chk(d, 8'h00);
    wr(8'h14, 8'hff);
    rd(8'h14, d);
    chk(d, 8'hf8);
    wr(8'h15, 8'hff);
    rd(8'h15, d);
    chk(d, 8'he8);
    wr(8'h20, 8'hff);
    rd(8'h20, d);
    chk(d, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h15, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_ts16();
    wr(8'h13, 8'h0b);
    ts16(1'b1, 1'b1);
    chk(ts, 8'h0b);
    wr(8'h13, 8'ha5);
    ts16(1'b1, 1'b1);
    chk(ts, 8'ha5);
    wr(8'h13, 8'h57);
    auto <= 1'b0;
    ts16(1'b1, 1'b1);
    chk(ts, 8'h53);
    auto <= 1'b1;
    wr(8'h13, 8'h0b);
    @(posedge clk);
    mfs <= 1'b1;
    @(posedge clk);
    mfs <= 1'b0;
    wr(8'h13, 8'hf0);
    ts16(1'b0, 1'b1);
    chk(ts, 8'h0b);
    ts16(1'b1, 1'b1);
    chk(ts, 8'hf0);
    ts16(1'b0, 1'b0);
    chk(ts, sigb);
    wr(8'h14, 8'h20);
    ts16(1'b1, 1'b1);
    chk(ts, rxb);
    chk(8'(ccs), 8'h01);
    lsel <= 1'b1;
    ts16(1'b0, 1'b0);
    chk(ts, hdlb);
    chk(8'(conn), 8'h01);
    wr(8'h14, 8'h00);
    ts16(1'b0, 1'b0);
    chk(ts, sigb);
    chk(8'(conn), 8'h00);
    lsel <= 1'b0;
    $display("test ts16 done");
  endtask
  task automatic t_pins();
    wr(8'h14, 8'h88);
    ntx <= 4'ha;
    sin <= 8'h5c;
    cyc(3);
    chk(8'(doe), 8'h01);
    chk(8'(soe), 8'h00);
    chk(8'(sout[7:4]), 8'h0a);
    chk(8'(nrx), 8'h05);
    wr(8'h14, 8'h40);
    cyc(3);
    chk(8'(doe), 8'h00);
    chk(8'(soe), 8'h01);
    chk(8'(sout[3:0]), 8'h0a);
    chk(8'(nrx), 8'h0c);
    raw <= 4'h5;
    cyc(3);
    chk(8'(sst), 8'h05);
    wr(8'h14, 8'h10);
    raw <= 4'ha;
    cyc(DEB / 2);
    chk(8'(sst), 8'h05);
    cyc(DEB + 5);
    chk(8'(sst), 8'h0a);
    wr(8'h14, 8'h00);
    $display("test pins done");
  endtask
  task automatic t_loop();
    wr(8'h15, 8'h08);
    cyc(40);
    ones = 0;
    run <= 1'b0;
    cyc(4);
    push(1'b1);
    push(1'b1);
    @(posedge clk);
    dvld <= 1'b1;
    cyc(4);
    chk(8'(rdy), 8'h00);
    run <= 1'b1;
    wait_acc();
    push(1'b1);
    push(1'b0);
    push(1'b1);
    push(1'b1);
    cyc(150);
    chk(8'(ones), 8'h06);
    $display("test loop done");
  endtask
  task automatic t_code();
    wr(8'h15, 8'h28);
    window();
    chk(8'(ones != 0), 8'h01);
    wr(8'h15, 8'ha8);
    window();
    chk(8'(ones), 8'h00);
    wr(8'h15, 8'h08);
    window();
    chk(8'(ones), 8'h00);
    mark <= 1'b1;
    wr(8'h15, 8'h40);
    window();
    chk(8'(ones), 8'h00);
    wr(8'h15, 8'h00);
    window();
    chk(8'(ones > 40), 8'h01);
    mark <= 1'b0;
    $display("test code done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_ts16();
    t_pins();
    t_loop();
    t_code();
    print_verdict();
  end
  // Tests need some 1600 cycles; this limit of 20000 cycles leaves ample margin
  initial begin
    #(50 * 20000);
    bad_count++;
    print_verdict();
  end
endmodule // testbench
